// File: core/qpsc_pkg.sv
package qpsc_pkg;

    // ------------------------------------------------------------
    // Command codes.
    // ------------------------------------------------------------
    localparam logic [7:0] CMD_READ_SLOW = 8'h03;
    localparam logic [7:0] CMD_READ_LOW = 8'h0B;
    localparam logic [7:0] CMD_READ_QUAD = 8'hEB;
    localparam logic [7:0] CMD_READ_WRAP = 8'h8B;
    localparam logic [7:0] CMD_WRITE = 8'h02;
    localparam logic [7:0] CMD_WRITE_QUAD = 8'h38;
    localparam logic [7:0] CMD_WRITE_WRAP = 8'h82;
    localparam logic [7:0] CMD_MODE_READ = 8'hB5;
    localparam logic [7:0] CMD_MODE_WRITE = 8'hB1;
    localparam logic [7:0] CMD_QUAD_ENTER = 8'h35;
    localparam logic [7:0] CMD_QUAD_EXIT = 8'hF5;
    localparam logic [7:0] CMD_RESET_ARM = 8'h66;
    localparam logic [7:0] CMD_RESET = 8'h99;

    // ------------------------------------------------------------
    // Field positions, reset values and counts.
    // ------------------------------------------------------------
    localparam int WRAP_LSB = 5;
    localparam logic [1:0] WRAP_RESET = 2'h3;
    localparam logic [7:0] MODE_RESET = 8'h60;
    localparam logic [3:0] ADDR_NIBBLES = 4'h6;
    localparam logic [3:0] READ_WAIT_FAST = 4'h6;
    localparam logic [3:0] READ_WAIT_LOW = 4'h4;
    localparam logic [3:0] WAIT_NONE = 4'h0;

    // Phases of a quad frame.
    typedef enum logic [2:0] {
        PH_IDLE,
        PH_CMD,
        PH_ADDR,
        PH_WAIT,
        PH_DATA,
        PH_IGNORE
    } qpsc_phase_e;

    // Memory access request toward the storage array.
    typedef struct packed {
        logic write;
        logic [23:0] addr;
        logic [7:0] data;
    } qpsc_mem_req_s;

endpackage

// File: core/qpsc_device.sv
`timescale 1ns/1ps
// Summary of operation
// RL1: Read nibbles launched after serial clock falls.
// RL2: Low-speed fast read accepted, host limits clock.
// RL3: High-speed quad read, burst per wrap setting.
// RL4: Wrapped read always wraps at configured length.
// RL5: Both write opcodes behave identically.
// RL6: Wrapped write always wraps at configured length.
// RL7: Quad exit returns to serial mode.
// RL8: Completed reset gives serial standby.
// RL9: Reset needs arm command directly before.
// RL10: Other command after arm cancels pending reset.
// RL11: Host waits 50 ns after reset.
// RL12: Host respects per-command clock limits.
// RL13: Host keeps chip enable high 18 ns.
// RL14: Host bounds chip enable low time.
// RL15: Host waits 150 us after sleep exit.
// RL16: Only linear 2048 bursts cross pages.
// RL17: Host samples fast reads on falling edge; the host model samples just before the rising edge.
// RL18: Reset commands recognised in both modes.
// RL19: Wrap field selects 16/32/64/2048 bytes.
// RL20: Quad mode entered only from serial mode.
// RL21: Chip enable high ends access, standby.
// RL22: Opcode, address, data sent high nibble first.
module qpsc_device (
    input wire logic sysClk,
    input wire logic rst,
    input wire logic linkClk,
    input wire logic chipEnableN,
    input wire logic [3:0] quadIoLinesIn,
    output logic [3:0] quadIoLinesOut,
    output logic [3:0] quadIoLinesOeN,
    output logic fourLineMode,
    output logic [7:0] modeConfigReg,
    output qpsc_pkg::qpsc_mem_req_s memReq,
    output logic memReqValid,
    input wire logic [7:0] memRdData
);
    import qpsc_pkg::*;

    // ------------------------------------------------------------
    // Input synchronisers.
    // ------------------------------------------------------------
    // The link clock is sampled like any other pin, so the host clock must
    // stay several system clocks per phase for edges to be found reliably.
    // All edge detection works on the second stage only; the first stage
    // may be metastable and is never read by logic.
    // Chip enable resets to high in both stages, so no false frame start
    // follows the end of reset.
    logic [5:0] syncA_r; // First stage: clock, chip enable, data.
    logic [5:0] syncB_r; // Second stage, the only reader of syncA_r.
    logic clkPrev_r; // Last synchronised clock, for edge finding.

    // Two flops for every pin input.
    always_ff @(posedge sysClk) begin
        if (rst) begin
            syncA_r <= 6'h02;
            syncB_r <= 6'h02;
            clkPrev_r <= 1'b0;
        end else begin
            syncA_r <= {quadIoLinesIn, chipEnableN, linkClk};
            syncB_r <= syncA_r;
            clkPrev_r <= syncB_r[0];
        end
    end

    logic sClk; // Synchronised link clock.
    logic ceN; // Synchronised chip enable, active low.
    logic [3:0] sIo; // Synchronised data lines.
    logic rise; // Rising edge of the link clock.
    logic fall; // Falling edge of the link clock.
    assign sClk = syncB_r[0];
    assign ceN = syncB_r[1];
    assign sIo = syncB_r[5:2];
    assign rise = sClk & ~clkPrev_r & ~ceN;
    assign fall = ~sClk & clkPrev_r & ~ceN;

    // ------------------------------------------------------------
    // Decode helpers.
    // ------------------------------------------------------------
    // Mask of wrap bits for the given wrap field.
    function automatic logic [10:0] wrapMask(input logic [1:0] code);
        case (code)
            2'h0: wrapMask = 11'h00F; // 16 bytes. RL19
            2'h1: wrapMask = 11'h01F; // 32 bytes.
            2'h2: wrapMask = 11'h03F; // 64 bytes.
            default: wrapMask = 11'h7FF; // 2048 bytes.
        endcase
    endfunction

    // Dummy cycles for a given opcode in quad mode.
    function automatic logic [3:0] waitOf(input logic [7:0] op);
        case (op)
            CMD_READ_LOW: waitOf = READ_WAIT_LOW; // RL2
            CMD_READ_QUAD, CMD_READ_WRAP, CMD_MODE_READ: waitOf = READ_WAIT_FAST;
            default: waitOf = WAIT_NONE;
        endcase
    endfunction

    // ------------------------------------------------------------
    // Frame state.
    // ------------------------------------------------------------
    qpsc_phase_e phase_r; // Current phase of the frame.
    logic [7:0] opcode_r; // Received opcode.
    logic [23:0] addr_r; // Running burst address.
    logic [3:0] count_r; // Nibble or wait counter.
    logic nibHalf_r; // Second nibble of a byte pending.
    logic [3:0] hiNib_r; // High nibble of a byte being written.
    logic [7:0] rdByte_r; // Byte being shifted out.
    logic armed_r; // Reset armed by previous command.
    logic isRead_r; // Frame is a read.
    logic forceWrap_r; // Frame wraps regardless of setting.
    logic cmdDone_r; // A full opcode has been taken.
    logic serialShift_r; // Serial-mode opcode shift in progress.
    logic [2:0] serialCnt_r; // Serial opcode bit counter.

    // Wrap-aware next address.
    // Only the low eleven bits take part in a wrap, so a wrapped burst never
    // leaves its page, while a linear run is free to carry into the page bits.
    logic [23:0] addrNext;
    logic [10:0] mask;
    always_comb begin
        mask = wrapMask(modeConfigReg[WRAP_LSB +: 2]);
        if (forceWrap_r || modeConfigReg[WRAP_LSB +: 2] != WRAP_RESET) begin
            // Wrap inside the selected burst. RL4 RL6 RL16
            addrNext = {addr_r[23:11], (addr_r[10:0] & ~mask) |
                        ((addr_r[10:0] + 11'h001) & mask)};
        end else begin
            // Linear run may cross pages. RL16 RL19
            addrNext = addr_r + 24'h000001;
        end
    end

    // Main frame sequencer on link clock edges.
    // Every phase advances only on a detected rising edge with chip enable low.
    // A frame cut short by chip enable returns straight to idle, whatever phase.
    always_ff @(posedge sysClk) begin
        if (rst) begin
            phase_r <= PH_IDLE;
            opcode_r <= 8'h00;
            addr_r <= 24'h000000;
            count_r <= 4'h0;
            nibHalf_r <= 1'b0;
            hiNib_r <= 4'h0;
            isRead_r <= 1'b0;
            forceWrap_r <= 1'b0;
            cmdDone_r <= 1'b0;
            serialShift_r <= 1'b0;
            serialCnt_r <= 3'h0;
        end else if (ceN) begin
            // Chip enable high ends any access and returns to standby. RL21
            phase_r <= PH_IDLE;
            nibHalf_r <= 1'b0;
            cmdDone_r <= 1'b0;
            serialCnt_r <= 3'h0;
            serialShift_r <= 1'b0;
        end else begin
            cmdDone_r <= 1'b0;
            if (rise) begin
                case (phase_r)
                    PH_IDLE: begin
                        if (fourLineMode) begin
                            opcode_r <= {opcode_r[3:0], sIo}; // RL22
                            phase_r <= PH_CMD;
                        end else begin
                            // Serial opcode shifts in on line 0.
                            opcode_r <= {opcode_r[6:0], sIo[0]};
                            serialCnt_r <= serialCnt_r + 3'h1;
                            serialShift_r <= 1'b1;
                            if (serialCnt_r == 3'h7) begin
                                cmdDone_r <= 1'b1;
                                phase_r <= PH_IGNORE;
                            end
                        end
                    end
                    PH_CMD: begin
                        opcode_r <= {opcode_r[3:0], sIo}; // RL22
                        cmdDone_r <= 1'b1;
                        count_r <= 4'h0;
                        case ({opcode_r[3:0], sIo})
                            CMD_READ_LOW, CMD_READ_QUAD: begin // RL2 RL3
                                phase_r <= PH_ADDR;
                                isRead_r <= 1'b1;
                                forceWrap_r <= 1'b0;
                            end
                            CMD_READ_WRAP: begin // RL4
                                phase_r <= PH_ADDR;
                                isRead_r <= 1'b1;
                                forceWrap_r <= 1'b1;
                            end
                            CMD_WRITE, CMD_WRITE_QUAD: begin // RL5
                                phase_r <= PH_ADDR;
                                isRead_r <= 1'b0;
                                forceWrap_r <= 1'b0;
                            end
                            CMD_WRITE_WRAP: begin // RL6
                                phase_r <= PH_ADDR;
                                isRead_r <= 1'b0;
                                forceWrap_r <= 1'b1;
                            end
                            default: phase_r <= PH_IGNORE;
                        endcase
                    end
                    PH_ADDR: begin
                        addr_r <= {addr_r[19:0], sIo}; // RL22
                        count_r <= count_r + 4'h1;
                        if (count_r == ADDR_NIBBLES - 4'h1) begin
                            count_r <= 4'h0;
                            phase_r <= (waitOf(opcode_r) == WAIT_NONE) ? PH_DATA : PH_WAIT;
                        end
                    end
                    PH_WAIT: begin
                        count_r <= count_r + 4'h1;
                        if (count_r == waitOf(opcode_r) - 4'h1) begin
                            phase_r <= PH_DATA;
                        end
                    end
                    PH_DATA: begin
                        nibHalf_r <= ~nibHalf_r;
                        if (!isRead_r && !nibHalf_r) begin
                            hiNib_r <= sIo; // RL22
                        end
                        if (nibHalf_r) begin
                            addr_r <= addrNext;
                        end
                    end
                    default: phase_r <= PH_IGNORE;
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // Memory requests: writes store bytes, reads fetch the next byte.
    // ------------------------------------------------------------
    always_ff @(posedge sysClk) begin
        if (rst) begin
            memReq <= '0;
            memReqValid <= 1'b0;
        end else begin
            memReqValid <= 1'b0;
            if (rise && !ceN && phase_r == PH_DATA && nibHalf_r && !isRead_r) begin
                memReq <= '{write: 1'b1, addr: addr_r, data: {hiNib_r, sIo}};
                memReqValid <= 1'b1;
            end else if (rise && !ceN && isRead_r &&
                         (phase_r == PH_WAIT || (phase_r == PH_DATA && nibHalf_r))) begin
                // Fetch the byte that the next pair of nibbles will carry.
                memReq <= '{write: 1'b0,
                            addr: (phase_r == PH_DATA) ? addrNext : addr_r,
                            data: 8'h00};
                memReqValid <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // Read data driver, launched on falling link clock edges.
    // ------------------------------------------------------------
    // The storage byte is taken at the high-nibble launch and kept, so the low
    // nibble is unaffected by the fetch of the following byte.
    // Lines are released as soon as chip enable is seen high.
    logic readOut_r; // Lines driven by the device.
    always_ff @(posedge sysClk) begin
        if (rst) begin
            quadIoLinesOut <= 4'h0;
            readOut_r <= 1'b0;
            rdByte_r <= 8'h00;
        end else if (ceN) begin
            readOut_r <= 1'b0;
        end else if (fall && phase_r == PH_DATA && isRead_r) begin
            // Launch after the falling edge, high nibble first. RL1 RL22
            readOut_r <= 1'b1;
            if (!nibHalf_r) begin
                quadIoLinesOut <= memRdData[7:4];
                rdByte_r <= memRdData;
            end else begin
                quadIoLinesOut <= rdByte_r[3:0];
            end
        end
    end
    assign quadIoLinesOeN = {4{~readOut_r}};

    // ------------------------------------------------------------
    // Mode, wrap setting and two-step reset.
    // ------------------------------------------------------------
    // Each completed opcode updates the armed flag, so a reset only takes
    // effect when it is the very next command after the arm.
    always_ff @(posedge sysClk) begin
        if (rst) begin
            fourLineMode <= 1'b0;
            armed_r <= 1'b0;
            modeConfigReg <= MODE_RESET;
        end else if (cmdDone_r) begin
            // Any command other than the arm clears the armed state. RL10
            armed_r <= (opcode_r == CMD_RESET_ARM); // RL9 RL18
            if (opcode_r == CMD_RESET && armed_r) begin
                // Back to serial standby with default settings. RL8 RL9 RL18
                fourLineMode <= 1'b0;
                modeConfigReg <= MODE_RESET;
            end else if (opcode_r == CMD_QUAD_EXIT && fourLineMode) begin
                fourLineMode <= 1'b0; // RL7
            end else if (opcode_r == CMD_QUAD_ENTER && !fourLineMode) begin
                fourLineMode <= 1'b1; // RL20
            end
        end
    end

endmodule

// File: tb/qpsc_device_chk.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// Port checker of the device.
// ------------------------------------------------------------
module qpsc_device_chk (
    input wire logic sysClk,
    input wire logic rst,
    input wire logic linkClk,
    input wire logic chipEnableN,
    input wire logic [3:0] quadIoLinesIn,
    input wire logic [3:0] quadIoLinesOut,
    input wire logic [3:0] quadIoLinesOeN,
    input wire logic fourLineMode,
    input wire logic [7:0] modeConfigReg,
    input wire qpsc_pkg::qpsc_mem_req_s memReq,
    input wire logic memReqValid,
    input wire logic [7:0] memRdData
);
    import qpsc_pkg::*;
    default clocking cb @(posedge sysClk);
    endclocking
    default disable iff (rst);
    // Chip enable has been high long enough to pass the synchronisers.
    sequence ceIdle;
        chipEnableN [*6];
    endsequence
    a_reset_values: assert property (
        $past(rst) |-> !fourLineMode && quadIoLinesOeN == 4'hF && !memReqValid)
        else $error("state after reset wrong");
    a_wrap_default: assert property (
        modeConfigReg == MODE_RESET) else $error("wrap setting moved");
    a_idle_release: assert property (
        ceIdle |-> quadIoLinesOeN == 4'hF) else $error("lines driven while idle");
    a_out_after_fall: assert property (
        $changed(quadIoLinesOut) |-> !linkClk && !$past(linkClk))
        else $error("read nibble moved outside falling edge");
    a_oe_whole_bus: assert property (
        quadIoLinesOeN != 4'hF |-> quadIoLinesOeN == 4'h0 && fourLineMode)
        else $error("bad output enable");
    a_req_quad_only: assert property (
        memReqValid |-> fourLineMode && !chipEnableN) else $error("access outside quad");
    a_req_on_rise: assert property (
        memReqValid |-> linkClk && $past(linkClk, 2)) else $error("access off rising edge");
    a_valid_pulse: assert property (
        memReqValid |=> !memReqValid) else $error("access pulse too long");
endmodule

// File: tb/qpsc_host_model.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// Host controller model: clock, chip enable and lines.
// ------------------------------------------------------------
module qpsc_host_model (
    input wire logic sysClk,
    output logic linkClk,
    output logic chipEnableN,
    output logic [3:0] quadIoLinesIn,
    input wire logic [3:0] quadIoLinesOut
);
    import qpsc_pkg::*;
    // Link clock idles low and the chip stays deselected.
    initial begin
        linkClk = 1'b0;
        chipEnableN = 1'b1;
        quadIoLinesIn = 4'h0;
    end
    // One link cycle of 160 ns, far below every clock limit.
    task nib(input logic [3:0] n, output logic [3:0] got);
        @(posedge sysClk);
        quadIoLinesIn <= n;
        repeat (9) @(posedge sysClk);
        got = quadIoLinesOut;
        linkClk <= 1'b1;
        repeat (10) @(posedge sysClk);
        linkClk <= 1'b0;
    endtask
    // One framed command; reads return the nibbles seen in the data phase.
    task frame(input logic quad, input logic [7:0] op, input logic [23:0] adr, input int na,
        input int nw, input logic wr, input logic [7:0] wd, input int nd,
        output logic [15:0] rd);
        logic [3:0] q[$];
        logic [3:0] g;
        int i;
        q = {};
        rd = 16'h0000;
        if (quad) begin
            q = {op[7:4], op[3:0]};
        end else begin
            for (i = 7; i >= 0; i--) q.push_back({3'h0, op[i]});
        end
        for (i = 0; i < na; i++) q.push_back(adr[23 - 4 * i -: 4]);
        if (wr) begin
            q.push_back(wd[7:4]);
            q.push_back(wd[3:0]);
        end
        @(posedge sysClk);
        chipEnableN <= 1'b0;
        foreach (q[k]) nib(q[k], g);
        // Released lines show the inverse of the last value.
        for (i = 0; i < nw + nd; i++) begin
            nib(~quadIoLinesIn, g);
            if (i >= nw) begin
                rd = {rd[11:0], g};
            end
        end
        // Raise chip enable right after the last data, then a gap of 80 ns.
        repeat (2) @(posedge sysClk);
        chipEnableN <= 1'b1;
        quadIoLinesIn <= ~quadIoLinesIn;
        repeat (10) @(posedge sysClk);
    endtask
endmodule

// File: tb/qpsc_device_tb.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// Self-checking bench of the device.
// ------------------------------------------------------------
module qpsc_device_tb;
    import qpsc_pkg::*;
    logic sysClk, rst, linkClk, chipEnableN, fourLineMode, memReqValid, gotReq;
    logic [3:0] ioIn, ioOut, ioOeN;
    logic [7:0] modeConfigReg, memRdData;
    logic [15:0] rd;
    qpsc_mem_req_s memReq, firstReq;
    int bad_count, comparisons;
    qpsc_device i_qpsc_device (.sysClk(sysClk), .rst(rst), .linkClk(linkClk),
        .chipEnableN(chipEnableN), .quadIoLinesIn(ioIn), .quadIoLinesOut(ioOut),
        .quadIoLinesOeN(ioOeN), .fourLineMode(fourLineMode), .modeConfigReg(modeConfigReg),
        .memReq(memReq), .memReqValid(memReqValid), .memRdData(memRdData));
    qpsc_host_model i_qpsc_host_model (.sysClk(sysClk), .linkClk(linkClk),
        .chipEnableN(chipEnableN), .quadIoLinesIn(ioIn), .quadIoLinesOut(ioOut));
    // Clock of 8 ns.
    initial begin
        sysClk = 1'b0;
        forever #4 sysClk = ~sysClk;
    end
    // Keeps the first storage access of each frame.
    always @(posedge sysClk) begin
        if (memReqValid === 1'b1 && !gotReq) begin
            firstReq <= memReq;
            gotReq <= 1'b1;
        end
    end
    task check(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            bad_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task cmd(input logic quad, input logic [7:0] op);
        i_qpsc_host_model.frame(quad, op, 24'h000000, 0, 0, 1'b0, 8'h00, 0, rd);
    endtask
    task t_enter;
        cmd(1'b0, CMD_QUAD_ENTER);
        check(fourLineMode, 32'h1);
    endtask
    task t_write(input logic [7:0] op);
        gotReq = 1'b0;
        i_qpsc_host_model.frame(1'b1, op, 24'h5A1C3E, 6, 0, 1'b1, 8'h3C, 0, rd);
        check(firstReq.write, 32'h1);
        check(firstReq.addr, 32'h5A1C3E);
        check(firstReq.data, 32'h3C);
    endtask
    task t_read(input logic [7:0] op, input int nw, input logic [7:0] d);
        gotReq = 1'b0;
        @(posedge sysClk);
        memRdData <= d;
        i_qpsc_host_model.frame(1'b1, op, 24'h00F0A2, 6, nw, 1'b0, 8'h00, 4, rd);
        check(rd, {d, d});
        check(firstReq.write, 32'h0);
        check(firstReq.addr, 32'h00F0A2);
    endtask
    task t_reset_pair;
        cmd(1'b1, CMD_RESET_ARM);
        t_write(CMD_WRITE_QUAD);
        cmd(1'b1, CMD_RESET);
        check(fourLineMode, 32'h1);
        cmd(1'b1, CMD_RESET_ARM);
        cmd(1'b1, CMD_RESET);
        check(fourLineMode, 32'h0);
        check(modeConfigReg, 32'h60);
    endtask
    task t_exit;
        cmd(1'b1, CMD_QUAD_EXIT);
        check(fourLineMode, 32'h0);
        check(ioOeN, 32'hF);
        cmd(1'b0, CMD_RESET_ARM);
        cmd(1'b0, CMD_RESET);
        check(fourLineMode, 32'h0);
    endtask
    task end_of_test;
        if (bad_count == 0 && comparisons > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // Main sequence.
    initial begin
        rst = 1'b1;
        memRdData = 8'h00;
        gotReq = 1'b0;
        bad_count = 0;
        comparisons = 0;
        repeat (20) @(posedge sysClk);
        rst <= 1'b0;
        repeat (2) @(posedge sysClk);
        check(fourLineMode, 32'h0);
        check(ioOeN, 32'hF);
        t_enter;
        t_write(CMD_WRITE);
        t_write(CMD_WRITE_QUAD);
        t_write(CMD_WRITE_WRAP);
        t_read(CMD_READ_LOW, 4, 8'hA5);
        t_read(CMD_READ_QUAD, 6, 8'h96);
        t_read(CMD_READ_WRAP, 6, 8'h3C);
        t_reset_pair;
        t_enter;
        t_exit;
        end_of_test;
    end
    // Watchdog of 500 us.
    initial begin
        repeat (62500) @(posedge sysClk);
        bad_count++;
        end_of_test;
    end
endmodule
bind qpsc_device qpsc_device_chk i_qpsc_device_chk (.sysClk(sysClk), .rst(rst),
    .linkClk(linkClk), .chipEnableN(chipEnableN), .quadIoLinesIn(quadIoLinesIn),
    .quadIoLinesOut(quadIoLinesOut), .quadIoLinesOeN(quadIoLinesOeN),
    .fourLineMode(fourLineMode), .modeConfigReg(modeConfigReg), .memReq(memReq),
    .memReqValid(memReqValid), .memRdData(memRdData));
